/* hdl/pmc_ctrl.sv */
// Purpose: Power mode controller steering run, wait and stop configurations.
// Assumes: Core sleep instructions arrive as one-cycle pulses on the system clock.
// Notes: Async wake-up input comes from the always-on interrupt logic.
`timescale 1ns/10ps
module pmc_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic wait_for_interrupt_instr_i,
  input wire logic wait_for_event_instr_i,
  input wire logic deep_sleep_sel_i,
  input wire logic vlp_stop_sel_i,
  input wire logic vlp_run_req_i,
  input wire logic nested_vector_irq_ctrl_wake_i,
  input wire logic async_wakeup_irq_ctrl_wake_async_i,
  input wire logic [11:0] periph_lp_clk_i,
  output logic [5:0] mode_o,
  output logic core_clk_en_o,
  output logic reduced_freq_o,
  output logic low_voltage_detect_en_o,
  output logic nested_vector_irq_ctrl_en_o,
  output logic async_wakeup_irq_ctrl_en_o,
  output logic sram_retain_o,
  output logic [11:0] periph_en_o,
  output logic [11:0] wake_src_en_o,
  output logic wake_pulse_o
);

  pmc_pkg::pmc_mode_type state_q, state_d;
  logic run_vlp_q, run_vlp_d;
  logic async_wakeup_irq_ctrl_wake;
  logic core_clk_en_q;
  logic reduced_freq_q;
  logic lvd_en_q;
  logic nested_vector_irq_ctrl_en_q;
  logic async_wakeup_irq_ctrl_en_q;
  logic sram_ret_q;
  logic [11:0] periph_en_q;
  logic [11:0] wake_src_q;
  logic wake_q;

  pmc_sync u_async_wakeup_irq_ctrl_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .async_i(async_wakeup_irq_ctrl_wake_async_i),
    .level_o(async_wakeup_irq_ctrl_wake)
  );

  wire logic sleep_instr = wait_for_interrupt_instr_i | wait_for_event_instr_i;
  wire logic in_run = (state_q == pmc_pkg::PMC_RUN) || (state_q == pmc_pkg::PMC_VERY_LOW_POWER_RUN);
  wire logic in_wait = (state_q == pmc_pkg::PMC_WAIT) || (state_q == pmc_pkg::PMC_VERY_LOW_POWER_WAIT);
  wire logic in_stop = (state_q == pmc_pkg::PMC_STOP) || (state_q == pmc_pkg::PMC_VERY_LOW_POWER_STOP);
  wire logic wake_now = (in_wait && nested_vector_irq_ctrl_wake_i) || (in_stop && async_wakeup_irq_ctrl_wake);
  wire pmc_pkg::pmc_mode_type run_mode = run_vlp_q ? pmc_pkg::PMC_VERY_LOW_POWER_RUN : pmc_pkg::PMC_RUN;

  // Run flavour only changes while running, so wake returns to entry config
  always_comb begin
    run_vlp_d = run_vlp_q;
    if (in_run && !sleep_instr) begin
      run_vlp_d = vlp_run_req_i;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      pmc_pkg::PMC_RUN, pmc_pkg::PMC_VERY_LOW_POWER_RUN: begin
        if (sleep_instr) begin
          if (!deep_sleep_sel_i) begin
            state_d = run_vlp_q ? pmc_pkg::PMC_VERY_LOW_POWER_WAIT : pmc_pkg::PMC_WAIT;
          end else begin
            state_d = vlp_stop_sel_i ? pmc_pkg::PMC_VERY_LOW_POWER_STOP : pmc_pkg::PMC_STOP;
          end
        end else begin
          state_d = vlp_run_req_i ? pmc_pkg::PMC_VERY_LOW_POWER_RUN : pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_WAIT, pmc_pkg::PMC_VERY_LOW_POWER_WAIT, pmc_pkg::PMC_STOP, pmc_pkg::PMC_VERY_LOW_POWER_STOP: begin
        if (wake_now) begin
          state_d = run_mode;
        end
      end
      default: begin
        state_d = pmc_pkg::PMC_RUN;
      end
    endcase
  end

  // Output decode per target state, so outputs follow the mode with no lag
  logic core_d, red_d, lvd_d, nested_vector_irq_ctrl_d, async_wakeup_irq_ctrl_d, sram_d;
  logic [11:0] per_d, wsrc_d;
  always_comb begin
    core_d = 1'b1;
    red_d = 1'b0;
    lvd_d = 1'b1;
    nested_vector_irq_ctrl_d = 1'b1;
    async_wakeup_irq_ctrl_d = 1'b0;
    sram_d = 1'b1;
    per_d = pmc_pkg::PMC_PER_ALL;
    wsrc_d = 12'h000;
    case (state_d)
      pmc_pkg::PMC_RUN: begin
        lvd_d = 1'b1;
      end
      pmc_pkg::PMC_VERY_LOW_POWER_RUN: begin
        red_d = 1'b1;
        lvd_d = 1'b0;
      end
      pmc_pkg::PMC_WAIT: begin
        core_d = 1'b0;
      end
      pmc_pkg::PMC_VERY_LOW_POWER_WAIT: begin
        core_d = 1'b0;
        red_d = 1'b1;
        lvd_d = 1'b0;
      end
      pmc_pkg::PMC_STOP: begin
        core_d = 1'b0;
        nested_vector_irq_ctrl_d = 1'b0;
        async_wakeup_irq_ctrl_d = 1'b1;
        per_d = pmc_pkg::PMC_PER_STOP;
        wsrc_d = pmc_pkg::PMC_PER_STOP;
      end
      pmc_pkg::PMC_VERY_LOW_POWER_STOP: begin
        core_d = 1'b0;
        red_d = 1'b1;
        lvd_d = 1'b0;
        nested_vector_irq_ctrl_d = 1'b0;
        async_wakeup_irq_ctrl_d = 1'b1;
        // Clock-dependent units stay on only when fed from a low-power source
        per_d = pmc_pkg::PMC_PER_VERY_LOW_POWER_STOP & (~pmc_pkg::PMC_PER_CLKDEP | periph_lp_clk_i);
        wsrc_d = per_d & ~(12'h1 << pmc_pkg::PMC_B_DMA);
      end
      default: begin
        core_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= pmc_pkg::PMC_RUN;
      run_vlp_q <= pmc_pkg::PMC_RST_VLP_RUN;
    end else if (clk_en_i) begin
      state_q <= state_d;
      run_vlp_q <= run_vlp_d;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_clk_en_q <= 1'b1;
      reduced_freq_q <= 1'b0;
      lvd_en_q <= 1'b1;
      nested_vector_irq_ctrl_en_q <= 1'b1;
      async_wakeup_irq_ctrl_en_q <= 1'b0;
      sram_ret_q <= 1'b1;
      periph_en_q <= pmc_pkg::PMC_PER_ALL;
      wake_src_q <= 12'h000;
      wake_q <= 1'b0;
    end else if (clk_en_i) begin
      core_clk_en_q <= core_d;
      reduced_freq_q <= red_d;
      lvd_en_q <= lvd_d;
      nested_vector_irq_ctrl_en_q <= nested_vector_irq_ctrl_d;
      async_wakeup_irq_ctrl_en_q <= async_wakeup_irq_ctrl_d;
      sram_ret_q <= sram_d;
      periph_en_q <= per_d;
      wake_src_q <= wsrc_d;
      wake_q <= wake_now;
    end
  end

  assign mode_o = state_q;
  assign core_clk_en_o = core_clk_en_q;
  assign reduced_freq_o = reduced_freq_q;
  assign low_voltage_detect_en_o = lvd_en_q;
  assign nested_vector_irq_ctrl_en_o = nested_vector_irq_ctrl_en_q;
  assign async_wakeup_irq_ctrl_en_o = async_wakeup_irq_ctrl_en_q;
  assign sram_retain_o = sram_ret_q;
  assign periph_en_o = periph_en_q;
  assign wake_src_en_o = wake_src_q;
  assign wake_pulse_o = wake_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_sleep_entry_class: assert property (
    clk_en_i && in_run && sleep_instr && deep_sleep_sel_i |=> in_stop)
    else $error("deep sleep did not enter stop class");
  a_sleep_wait_class: assert property (
    clk_en_i && in_run && sleep_instr && !deep_sleep_sel_i |=> in_wait)
    else $error("light sleep did not enter wait class");
  a_run_core_on: assert property (
    in_run |-> core_clk_en_o && periph_en_o == pmc_pkg::PMC_PER_ALL)
    else $error("run mode lost core or peripherals");
  a_run_lvd_on: assert property (
    state_q == pmc_pkg::PMC_RUN |-> low_voltage_detect_en_o && !reduced_freq_o)
    else $error("normal run not full config");
  a_very_low_power_run_lvd_off: assert property (
    state_q == pmc_pkg::PMC_VERY_LOW_POWER_RUN |-> !low_voltage_detect_en_o && reduced_freq_o)
    else $error("vlp run config wrong");
  a_wait_core_off: assert property (
    state_q == pmc_pkg::PMC_WAIT |-> !core_clk_en_o && nested_vector_irq_ctrl_en_o)
    else $error("wait config wrong");
  a_very_low_power_wait_config: assert property (
    state_q == pmc_pkg::PMC_VERY_LOW_POWER_WAIT |-> !core_clk_en_o && reduced_freq_o && !low_voltage_detect_en_o)
    else $error("vlp wait config wrong");
  a_stop_config: assert property (
    state_q == pmc_pkg::PMC_STOP |-> !nested_vector_irq_ctrl_en_o && low_voltage_detect_en_o
      && periph_en_o == pmc_pkg::PMC_PER_STOP && sram_retain_o)
    else $error("stop config wrong");
  a_very_low_power_stop_nested_vector_irq_ctrl_off: assert property (
    state_q == pmc_pkg::PMC_VERY_LOW_POWER_STOP |-> !nested_vector_irq_ctrl_en_o && !low_voltage_detect_en_o)
    else $error("vlp stop config wrong");
  a_wait_wake_nested_vector_irq_ctrl: assert property (
    clk_en_i && in_wait && nested_vector_irq_ctrl_wake_i |=> in_run && wake_pulse_o)
    else $error("wait did not wake on nested irq");
  a_stop_ignores_nested_vector_irq_ctrl: assert property (
    clk_en_i && in_stop && nested_vector_irq_ctrl_wake_i && !async_wakeup_irq_ctrl_wake |=> in_stop)
    else $error("stop woke on nested irq");
  a_wake_restores_run: assert property (
    clk_en_i && !in_run && wake_now |=> state_q == $past(run_mode))
    else $error("wake did not restore run config");
  a_clkdep_wake: assert property (
    state_q == pmc_pkg::PMC_VERY_LOW_POWER_STOP |-> (wake_src_en_o & pmc_pkg::PMC_PER_CLKDEP & ~periph_lp_clk_i) == 12'h000
      || $changed(periph_lp_clk_i))
    else $error("clock-dependent wake source enabled");

  c_wait_cycle: cover property (in_run ##1 in_wait ##[1:20] in_run);
  c_stop_cycle: cover property (state_q == pmc_pkg::PMC_STOP ##[1:40] in_run);
  c_very_low_power_stop_cycle: cover property (state_q == pmc_pkg::PMC_VERY_LOW_POWER_STOP ##[1:40] state_q == pmc_pkg::PMC_VERY_LOW_POWER_RUN);

endmodule

/* hdl/pmc_pkg.sv */
// Purpose: Shared constants and types for the power mode controller.
// Assumes: One system clock at 125 MHz, asynchronous active-high reset.
// Notes: Peripheral enable vector bit positions are defined here.
package pmc_pkg;

  typedef enum logic [5:0] {
    PMC_RUN       = 6'h01,
    PMC_VERY_LOW_POWER_RUN      = 6'h02,
    PMC_WAIT      = 6'h04,
    PMC_VERY_LOW_POWER_WAIT      = 6'h08,
    PMC_STOP      = 6'h10,
    PMC_VERY_LOW_POWER_STOP      = 6'h20
  } pmc_mode_type;

  // Peripheral enable vector layout
  localparam int PMC_PER_W = 12;
  localparam int PMC_B_CONV = 0;
  localparam int PMC_B_COMPARATOR = 1;
  localparam int PMC_B_LP_TIMER = 2;
  localparam int PMC_B_RTC = 3;
  localparam int PMC_B_PINIRQ = 4;
  localparam int PMC_B_XTAL = 5;
  localparam int PMC_B_PIT = 6;
  localparam int PMC_B_UART = 7;
  localparam int PMC_B_I2C = 8;
  localparam int PMC_B_SPI = 9;
  localparam int PMC_B_DMA = 10;
  localparam int PMC_B_OTHER = 11;

  localparam logic [11:0] PMC_PER_ALL = 12'hFFF;
  localparam logic [11:0] PMC_PER_STOP = 12'h01F;
  localparam logic [11:0] PMC_PER_VERY_LOW_POWER_STOP = 12'h7EF;

  // Serial and periodic timer bits that need a low-power clock source in very-low-power stop
  localparam logic [11:0] PMC_PER_CLKDEP = 12'h3C0;

  // Reset values
  localparam logic PMC_RST_VLP_RUN = 1'b0;
  localparam logic PMC_RST_DEEP = 1'b0;
  localparam logic PMC_RST_VLP_STOP = 1'b0;

  // Input synchroniser depth
  localparam int PMC_SYNC_STAGES = 3;

endpackage

/* hdl/pmc_sync.sv */
// Purpose: Three-stage synchroniser for an asynchronous wake-up level.
// Assumes: Clock enable freezes the chain like all other state.
// Notes: A change is accepted once the second and third stages agree.
`timescale 1ns/10ps
module pmc_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic async_i,
  output logic level_o
);

  logic [2:0] chain_q;
  logic level_q;
  wire logic agree = (chain_q[1] == chain_q[2]);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chain_q <= 3'h0;
      level_q <= 1'b0;
    end else if (clk_en_i) begin
      chain_q <= {chain_q[1:0], async_i};
      if (agree) begin
        level_q <= chain_q[2];
      end
    end
  end

  assign level_o = level_q;

endmodule

/* verification/pmc_core_model.sv */
// Purpose: Core-side partner issuing sleep instructions and wake-up requests.
// Assumes: Every request is launched on a rising edge by non-blocking assignment.
// Notes: The async wake level is only moved on edges; the synchroniser still sees it as async.
`timescale 1ns/10ps
module pmc_core_model (
  input wire logic clk_i,
  output logic wfi_o,
  output logic wfe_o,
  output logic nested_vector_irq_ctrl_wake_o,
  output logic async_wakeup_irq_ctrl_wake_o
);
  initial begin
    wfi_o = 1'b0;
    wfe_o = 1'b0;
    nested_vector_irq_ctrl_wake_o = 1'b0;
    async_wakeup_irq_ctrl_wake_o = 1'b0;
  end

  // One-cycle instruction pulse; returns at the edge that samples it
  task automatic sleep_instr(input bit use_wfe);
    @(posedge clk_i);
    if (use_wfe) wfe_o <= 1'b1;
    else wfi_o <= 1'b1;
    @(posedge clk_i);
    wfi_o <= 1'b0;
    wfe_o <= 1'b0;
  endtask

  task automatic nested_vector_irq_ctrl_pulse();
    @(posedge clk_i);
    nested_vector_irq_ctrl_wake_o <= 1'b1;
    @(posedge clk_i);
    nested_vector_irq_ctrl_wake_o <= 1'b0;
  endtask

  task automatic async_wakeup_irq_ctrl_level(input logic v);
    @(posedge clk_i);
    async_wakeup_irq_ctrl_wake_o <= v;
  endtask
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for the power mode controller.
// Assumes: Clock enable held high except in the freeze test; sleep and wake traffic comes from the core model.
// Notes: Wake source enables are only judged in stop class and in the two run checks after reset.
`timescale 1ns/10ps
module testbench;
  logic clk_i, sys_rst_i, deep_sel, vstop_sel, vrun_req, clk_en;
  logic [11:0] lp_clk, periph_en, wake_src;
  logic [5:0] mode, run_m, slp_m;
  logic core_en, red_f, lvd_en, nested_vector_irq_ctrl_en, async_wakeup_irq_ctrl_en, sram_r, wake_p, wait_for_interrupt_instr, wait_for_event_instr, nested_vector_irq_ctrl_w, async_wakeup_irq_ctrl_w;
  int fail_count, compares, cyc, n, k;
  integer seed;
  logic [31:0] r;

  pmc_core_model i_pmc_core_model (.clk_i(clk_i), .wfi_o(wait_for_interrupt_instr), .wfe_o(wait_for_event_instr), .nested_vector_irq_ctrl_wake_o(nested_vector_irq_ctrl_w),
    .async_wakeup_irq_ctrl_wake_o(async_wakeup_irq_ctrl_w));
  pmc_ctrl i_pmc_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wait_for_event_instr_i(wait_for_event_instr), .deep_sleep_sel_i(deep_sel),
    .vlp_stop_sel_i(vstop_sel), .vlp_run_req_i(vrun_req), .nested_vector_irq_ctrl_wake_i(nested_vector_irq_ctrl_w),
    .async_wakeup_irq_ctrl_wake_async_i(async_wakeup_irq_ctrl_w), .periph_lp_clk_i(lp_clk), .mode_o(mode), .core_clk_en_o(core_en),
    .reduced_freq_o(red_f), .low_voltage_detect_en_o(lvd_en), .nested_vector_irq_ctrl_en_o(nested_vector_irq_ctrl_en),
    .async_wakeup_irq_ctrl_en_o(async_wakeup_irq_ctrl_en), .sram_retain_o(sram_r), .periph_en_o(periph_en),
    .wake_src_en_o(wake_src), .wake_pulse_o(wake_p));

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Expected configuration for a mode: {core,reduced,lvd,nested_vector_irq_ctrl,async_wakeup_irq_ctrl,sram,periph,wake}
  function automatic logic [29:0] exp_cfg(input logic [5:0] m, input logic [11:0] lp);
    logic [11:0] per;
    logic [11:0] wk;
    logic [5:0] f;
    per = 12'hFFF;
    wk = 12'h000;
    if (m == 6'h10) begin
      per = 12'h01F;
      wk = 12'h01F;
    end
    if (m == 6'h20) begin
      per = 12'h7EF & ~(12'h3C0 & ~lp);
      wk = per & ~12'h400;
    end
    f = {m inside {6'h01, 6'h02}, m inside {6'h02, 6'h08, 6'h20}, m inside {6'h01, 6'h04, 6'h10},
         m inside {6'h01, 6'h02, 6'h04, 6'h08}, m inside {6'h10, 6'h20}, 1'b1};
    return {f, per, wk};
  endfunction

  task automatic chk_mode(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t mode got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t cfg got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input logic [5:0] m, input bit full);
    logic use_wk;
    use_wk = full || m inside {6'h10, 6'h20};
    chk_mode(mode, m);
    chk_cfg({2'b00, core_en, red_f, lvd_en, nested_vector_irq_ctrl_en, async_wakeup_irq_ctrl_en, sram_r, periph_en, use_wk ? wake_src : 12'h000},
      {2'b00, exp_cfg(m, lp_clk)});
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    seed = 32'h3904;
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    clk_en = 1'b1;
    deep_sel = 1'b0;
    vstop_sel = 1'b0;
    vrun_req = 1'b0;
    lp_clk = 12'h000;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk_state(pmc_pkg::PMC_RUN, 1'b1);
    // Clock enable low must freeze the run flavour despite a request
    @(posedge clk_i);
    clk_en <= 1'b0;
    vrun_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk_state(pmc_pkg::PMC_RUN, 1'b1);
    @(posedge clk_i);
    clk_en <= 1'b1;
    vrun_req <= 1'b0;
    $display("test freeze done");
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      r = $random(seed);
      vrun_req <= r[0];
      deep_sel <= r[1];
      vstop_sel <= r[2];
      lp_clk <= r[15:4];
      run_m = r[0] ? pmc_pkg::PMC_VERY_LOW_POWER_RUN : pmc_pkg::PMC_RUN;
      slp_m = !r[1] ? (r[0] ? pmc_pkg::PMC_VERY_LOW_POWER_WAIT : pmc_pkg::PMC_WAIT) : (r[2] ? pmc_pkg::PMC_VERY_LOW_POWER_STOP : pmc_pkg::PMC_STOP);
      @(posedge clk_i);
      #1;
      chk_state(run_m, 1'b0);
      i_pmc_core_model.sleep_instr(r[3]);
      #1;
      chk_state(slp_m, 1'b0);
      @(posedge clk_i);
      vrun_req <= ~r[0];
      if (r[1]) begin
        i_pmc_core_model.nested_vector_irq_ctrl_pulse();
        #1;
        chk_mode(mode, slp_m);
        i_pmc_core_model.async_wakeup_irq_ctrl_level(1'b1);
        k = 0;
        while (mode === slp_m && k < 10) begin
          @(posedge clk_i);
          #1;
          k++;
        end
      end else begin
        i_pmc_core_model.async_wakeup_irq_ctrl_level(1'b1);
        repeat (6) @(posedge clk_i);
        #1;
        chk_mode(mode, slp_m);
        i_pmc_core_model.async_wakeup_irq_ctrl_level(1'b0);
        repeat (6) @(posedge clk_i);
        i_pmc_core_model.nested_vector_irq_ctrl_pulse();
        #1;
      end
      chk_mode(mode, run_m);
      chk_cfg({31'h0, wake_p}, 32'h1);
      @(posedge clk_i);
      #1;
      chk_cfg({31'h0, wake_p}, 32'h0);
      i_pmc_core_model.async_wakeup_irq_ctrl_level(1'b0);
      repeat (6) @(posedge clk_i);
      $display("test %0d done", n);
    end
    tally_and_finish();
  end
endmodule
